// >>> core/hbp_defs.svh
// Register offsets, field positions, reset values and timing counts of the host port.
// Assumes a 20 MHz system clock on both ends of the port.
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

`define HBP_VIOL_HI_OFF     7'h50
`define HBP_VIOL_LO_OFF     7'h51
`define HBP_PAGE_OFF        7'h7F
`define HBP_MEM_SEL_BIT     6
`define HBP_PAGE_SET_LSB    0
`define HBP_PAGE_GRP_LSB    2
`define HBP_VIOL_RST        16'h0000
`define HBP_PAGE_SET_RST    2'h0
`define HBP_PAGE_GRP_RST    4'h0

`define HBP_CLK_NS          50
`define HBP_RD_SETTLE_NS    100
`define HBP_RD_SETTLE_CYC   ((`HBP_RD_SETTLE_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_ADDR_SETUP_NS   150
`define HBP_PHASE_CYC       ((`HBP_ADDR_SETUP_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_WR_PULSE_NS     300
`define HBP_WR_HOLD_CYC     ((`HBP_WR_PULSE_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)

`endif

// >>> core/hbp_device.sv
// Framer end of the host port: pin-side cycle engine, indirect page register, a 64-byte
// register array and four line code violation counters, one per framer register set.
// Assumes the host keeps strobes and address stable for several clock periods.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "hbp_defs.svh"
module hbp_device
  import hbp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  hbp_if.dev_mp           bus,
  input  wire logic [3:0] viol_event_in,
  output logic            reg_wr_pulse_out,
  output logic      [6:0] reg_wr_addr_out,
  output logic      [7:0] reg_wr_data_out,
  output logic      [1:0] page_set_out,
  output logic      [3:0] page_group_out
);
  typedef struct packed {
    hbp_dev_state_t       st;
    logic [2:0]           cnt;
    logic                 prev_ale;
    logic                 prev_rd;
    logic                 prev_wr;
    logic [6:0]           addr;
    logic [1:0]           page_set;
    logic [3:0]           page_grp;
    logic [7:0]           dout;
    logic                 oe;
    logic                 wb_v;
    logic [6:0]           wb_a;
    logic [7:0]           wb_d;
    logic                 wr_pulse;
    logic [6:0]           wr_a;
    logic [7:0]           wr_d;
    logic [63:0][7:0]     mem;
    logic [3:0][15:0]     viol;
  } hbp_dev_st_t;

  hbp_dev_st_t q;
  hbp_dev_st_t nxt_q;

  logic [21:0] pins_async;
  logic [21:0] pins_s;
  logic [2:0]  style_s;
  logic        cs_n_s;
  logic        ale_s;
  logic        rd_s;
  logic        wr_s;
  logic [6:0]  addr_s;
  logic [7:0]  data_s;

  assign pins_async = {bus.host_style_select, bus.cs_n, bus.address_latch_strobe,
                       bus.read_data_strobe_n, bus.write_strobe_n, bus.addr, bus.data_bus};

  hbp_sync #(.W(22)) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (pins_async),
    .sync_out   (pins_s)
  );

  assign {style_s, cs_n_s, ale_s, rd_s, wr_s, addr_s, data_s} = pins_s;

  // Address decode shared by every read path; holes in the map read as zero.
  function automatic logic [7:0] read_byte(input hbp_dev_st_t s, input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (!a[`HBP_MEM_SEL_BIT]) begin
      r = s.mem[a[5:0]];
    end else if (a == `HBP_VIOL_HI_OFF) begin
      r = s.viol[s.page_set][15:8];
    end else if (a == `HBP_VIOL_LO_OFF) begin
      r = s.viol[s.page_set][7:0];
    end else if (a == `HBP_PAGE_OFF) begin
      r = {2'h0, s.page_grp, s.page_set};
    end
    return r;
  endfunction

  logic sep;
  logic sel;
  logic ale_edge;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic rd_start;
  logic wr_start;
  logic wr_end;

  always_comb begin
    nxt_q    = q;
    sep      = (style_s != HBP_STYLE_DS);
    sel      = !cs_n_s;
    // The latch strobe is active high with separate strobes and active low otherwise.
    ale_edge = sep ? (q.prev_ale && !ale_s) : (!q.prev_ale && ale_s);
    rd_fall  = q.prev_rd && !rd_s;
    rd_rise  = !q.prev_rd && rd_s;
    wr_fall  = q.prev_wr && !wr_s;
    wr_rise  = !q.prev_wr && wr_s;
    // In the direction style the write pin carries read-high, write-low.
    rd_start = sel && rd_fall && (sep || wr_s);
    wr_start = sel && (sep ? wr_fall : (rd_fall && !wr_s));
    wr_end   = sep ? wr_rise : rd_rise;

    nxt_q.prev_ale = ale_s;
    nxt_q.prev_rd  = rd_s;
    nxt_q.prev_wr  = wr_s;
    nxt_q.wr_pulse = 1'b0;

    // The write buffer drains one cycle after capture, so the host may already be
    // running its next cycle while the byte lands.
    if (q.wb_v) begin
      nxt_q.wb_v     = 1'b0;
      nxt_q.wr_pulse = 1'b1;
      nxt_q.wr_a     = q.wb_a;
      nxt_q.wr_d     = q.wb_d;
      if (q.wb_a == `HBP_PAGE_OFF) begin
        nxt_q.page_set = q.wb_d[`HBP_PAGE_SET_LSB +: 2];
        nxt_q.page_grp = q.wb_d[`HBP_PAGE_GRP_LSB +: 4];
      end else if (!q.wb_a[`HBP_MEM_SEL_BIT]) begin
        nxt_q.mem[q.wb_a[5:0]] = q.wb_d;
      end
    end

    for (int i = 0; i < 4; i++) begin
      nxt_q.viol[i] = q.viol[i] + 16'(viol_event_in[i]);
    end

    if (sel && ale_edge && q.st == HBP_D_IDLE) begin
      nxt_q.addr = addr_s;
    end

    unique case (q.st)
      HBP_D_IDLE: begin
        if (rd_start) begin
          nxt_q.st   = HBP_D_RD_BUSY;
          nxt_q.cnt  = 3'h0;
          nxt_q.oe   = 1'b1;
          nxt_q.dout = read_byte(q, q.addr);
        end else if (wr_start) begin
          // With separate strobes the ready line never drops during a write.
          nxt_q.st  = sep ? HBP_D_WR_DONE : HBP_D_WR_BUSY;
          nxt_q.cnt = 3'h0;
        end
      end
      HBP_D_RD_BUSY, HBP_D_RD_DONE: begin
        nxt_q.cnt = q.cnt + 3'h1;
        if (q.st == HBP_D_RD_BUSY && q.cnt == 3'(`HBP_RD_SETTLE_CYC - 1)) begin
          nxt_q.st = HBP_D_RD_DONE;
        end
        if (rd_rise) begin
          nxt_q.st   = HBP_D_IDLE;
          nxt_q.oe   = 1'b0;
          nxt_q.addr = q.addr + 7'h01;
          // A counter event in the clearing cycle is kept as the first new count.
          if (q.addr == `HBP_VIOL_LO_OFF) begin
            nxt_q.viol[q.page_set] = {15'h0000, viol_event_in[q.page_set]};
          end
        end
      end
      HBP_D_WR_BUSY, HBP_D_WR_DONE: begin
        nxt_q.cnt = q.cnt + 3'h1;
        if (q.st == HBP_D_WR_BUSY && q.cnt == 3'(`HBP_RD_SETTLE_CYC - 1)) begin
          nxt_q.st = HBP_D_WR_DONE;
        end
        if (wr_end) begin
          nxt_q.st   = HBP_D_IDLE;
          nxt_q.wb_v = 1'b1;
          nxt_q.wb_a = q.addr;
          nxt_q.wb_d = data_s;
          nxt_q.addr = q.addr + 7'h01;
        end
      end
      default: begin
        nxt_q.st = HBP_D_IDLE;
        nxt_q.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q          <= '0;
      q.st       <= HBP_D_IDLE;
      q.prev_ale <= 1'b0;
      // The synchroniser also clears to zero, so this avoids a false strobe fall after reset.
      q.prev_rd  <= 1'b0;
      q.prev_wr  <= 1'b0;
      q.page_set <= `HBP_PAGE_SET_RST;
      q.page_grp <= `HBP_PAGE_GRP_RST;
      q.viol     <= {4{`HBP_VIOL_RST}};
    end else begin
      q <= nxt_q;
    end
  end

  // Ready is active high with separate strobes; the acknowledge is active low otherwise.
  assign bus.transfer_ack_out = sep ? (q.st != HBP_D_RD_BUSY)
                                    : !(q.st == HBP_D_RD_DONE || q.st == HBP_D_WR_DONE);
  assign bus.dev_data         = q.dout;
  assign bus.dev_data_oe      = q.oe;
  assign reg_wr_pulse_out     = q.wr_pulse;
  assign reg_wr_addr_out      = q.wr_a;
  assign reg_wr_data_out      = q.wr_d;
  assign page_set_out         = q.page_set;
  assign page_group_out       = q.page_grp;
endmodule

// >>> core/hbp_host.sv
// Processor end of the host port: turns one command into a full pin-level bus cycle.
// Assumes the framer end acknowledges every read and every direction-style write.
`timescale 1ns/1ps
`include "hbp_defs.svh"
module hbp_host
  import hbp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  hbp_if.host_mp          bus,
  input  wire logic [2:0] host_style_in,
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_write_in,
  input  wire logic [6:0] cmd_addr_in,
  input  wire logic [7:0] cmd_wdata_in,
  output logic            cmd_ready_out,
  output logic            rsp_valid_out,
  output logic      [7:0] rsp_rdata_out
);
  typedef struct packed {
    hbp_host_state_t st;
    logic [3:0]      cnt;
    logic [2:0]      style;
    logic            wr_cmd;
    logic            cs_n;
    logic            ale;
    logic            rd_n;
    logic            wr_n;
    logic [6:0]      addr;
    logic [7:0]      dout;
    logic            oe;
    logic            rsp_v;
    logic [7:0]      rsp_d;
  } hbp_host_st_t;

  hbp_host_st_t q;
  hbp_host_st_t nxt_q;
  logic [8:0]   back_s;
  logic         ack_s;
  logic [7:0]   data_s;
  logic         sep;
  logic         phase_done;

  hbp_sync #(.W(9)) u_back_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({bus.transfer_ack_out, bus.data_bus}),
    .sync_out   (back_s)
  );

  assign {ack_s, data_s} = back_s;

  always_comb begin
    nxt_q       = q;
    sep         = (q.style != HBP_STYLE_DS);
    phase_done  = (q.cnt == 4'(`HBP_PHASE_CYC - 1));
    nxt_q.cnt   = q.cnt + 4'h1;
    nxt_q.rsp_v = 1'b0;
    unique case (q.st)
      HBP_H_IDLE: begin
        nxt_q.style = host_style_in;
        nxt_q.cnt   = 4'h0;
        if (cmd_valid_in) begin
          nxt_q.st     = HBP_H_ALE_A;
          nxt_q.wr_cmd = cmd_write_in;
          nxt_q.addr   = cmd_addr_in;
          nxt_q.dout   = cmd_wdata_in;
          nxt_q.cs_n   = 1'b0;
          nxt_q.ale    = (q.style != HBP_STYLE_DS);
        end
      end
      HBP_H_ALE_A: begin
        if (phase_done) begin
          nxt_q.st  = HBP_H_ALE_B;
          nxt_q.cnt = 4'h0;
          nxt_q.ale = !sep;
          if (!sep) begin
            nxt_q.wr_n = !q.wr_cmd;
          end
        end
      end
      HBP_H_ALE_B: begin
        if (phase_done) begin
          nxt_q.st  = HBP_H_STRB;
          nxt_q.cnt = 4'h0;
          if (sep && q.wr_cmd) begin
            nxt_q.wr_n = 1'b0;
          end else begin
            nxt_q.rd_n = 1'b0;
          end
          nxt_q.oe = q.wr_cmd;
        end
      end
      HBP_H_STRB: begin
        if (sep && q.wr_cmd) begin
          if (q.cnt == 4'(`HBP_WR_HOLD_CYC - 1)) begin
            nxt_q.st   = HBP_H_END;
            nxt_q.cnt  = 4'h0;
            nxt_q.wr_n = 1'b1;
          end
        end else if (sep) begin
          // A stale high ready must not end the read, so the low phase is seen first.
          if (!ack_s) begin
            nxt_q.st = HBP_H_ACK;
          end
        end else if (!ack_s) begin
          nxt_q.st    = HBP_H_END;
          nxt_q.cnt   = 4'h0;
          nxt_q.rd_n  = 1'b1;
          nxt_q.rsp_v = !q.wr_cmd;
          nxt_q.rsp_d = data_s;
        end
      end
      HBP_H_ACK: begin
        if (ack_s) begin
          nxt_q.st    = HBP_H_END;
          nxt_q.cnt   = 4'h0;
          nxt_q.rd_n  = 1'b1;
          nxt_q.rsp_v = 1'b1;
          nxt_q.rsp_d = data_s;
        end
      end
      HBP_H_END: begin
        if (phase_done) begin
          nxt_q.st   = HBP_H_GAP;
          nxt_q.cnt  = 4'h0;
          nxt_q.oe   = 1'b0;
          nxt_q.cs_n = 1'b1;
          nxt_q.wr_n = 1'b1;
        end
      end
      HBP_H_GAP: begin
        if (phase_done) begin
          nxt_q.st  = HBP_H_IDLE;
          nxt_q.ale = (q.style == HBP_STYLE_DS);
        end
      end
      default: begin
        nxt_q.st = HBP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q      <= '0;
      q.st   <= HBP_H_IDLE;
      q.cs_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
    end else begin
      q <= nxt_q;
    end
  end

  assign bus.host_style_select    = q.style;
  assign bus.cs_n                 = q.cs_n;
  assign bus.address_latch_strobe = q.ale;
  assign bus.read_data_strobe_n   = q.rd_n;
  assign bus.write_strobe_n       = q.wr_n;
  assign bus.addr                 = q.addr;
  assign bus.host_data            = q.dout;
  assign bus.host_data_oe         = q.oe;
  assign cmd_ready_out            = (q.st == HBP_H_IDLE);
  assign rsp_valid_out            = q.rsp_v;
  assign rsp_rdata_out            = q.rsp_d;
endmodule

// >>> core/hbp_if.sv
// Pin bundle between the host processor end and the framer port end.
// The data bus level is resolved here from the two output enables; an undriven bus reads as
// all ones, as with pull-ups.
`timescale 1ns/1ps
interface hbp_if;
  logic [2:0] host_style_select;
  logic       cs_n;
  logic       address_latch_strobe;
  logic       read_data_strobe_n;
  logic       write_strobe_n;
  logic [6:0] addr;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic       transfer_ack_out;
  logic [7:0] data_bus;

  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);

  modport dev_mp (
    input  host_style_select, cs_n, address_latch_strobe, read_data_strobe_n,
    input  write_strobe_n, addr, data_bus,
    output dev_data, dev_data_oe, transfer_ack_out
  );

  modport host_mp (
    output host_style_select, cs_n, address_latch_strobe, read_data_strobe_n,
    output write_strobe_n, addr, host_data, host_data_oe,
    input  data_bus, transfer_ack_out
  );
endinterface

// >>> core/hbp_pkg.sv
// Types shared by both ends of the host port.
// Assumes hbp_defs.svh supplies the numeric constants.
package hbp_pkg;

  typedef enum logic [2:0] {
    HBP_STYLE_SEP = 3'h0,
    HBP_STYLE_DS  = 3'h1
  } hbp_style_t;

  typedef enum logic [2:0] {
    HBP_D_IDLE    = 3'h0,
    HBP_D_RD_BUSY = 3'h1,
    HBP_D_RD_DONE = 3'h2,
    HBP_D_WR_BUSY = 3'h3,
    HBP_D_WR_DONE = 3'h4
  } hbp_dev_state_t;

  typedef enum logic [2:0] {
    HBP_H_IDLE  = 3'h0,
    HBP_H_ALE_A = 3'h1,
    HBP_H_ALE_B = 3'h2,
    HBP_H_STRB  = 3'h3,
    HBP_H_ACK   = 3'h4,
    HBP_H_END   = 3'h5,
    HBP_H_GAP   = 3'h6
  } hbp_host_state_t;

endpackage

// >>> core/hbp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes the bundle's bits are levels that stay stable long enough to be sampled.
`timescale 1ns/1ps
module hbp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hbp_sync_st_t;

  hbp_sync_st_t q;
  hbp_sync_st_t nxt_q;

  // Only the second stage reads the first one.
  always_comb begin
    nxt_q    = q;
    nxt_q.s1 = async_in;
    nxt_q.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign sync_out = q.s2;
endmodule

// >>> testbench/hbp_monitor.sv
// Concurrent checks on the host port pins that join the two ends.
// Assumes one 20 MHz clock and a synchronous active-low reset for both ends.
`timescale 1ns/1ps
module hbp_monitor (
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic [2:0] host_style_select,
  input wire logic       cs_n,
  input wire logic       address_latch_strobe,
  input wire logic       read_data_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [6:0] addr,
  input wire logic       dev_data_oe,
  input wire logic       transfer_ack_out
);
  logic sep;

  // Every style code other than strobe plus direction behaves as separate strobes.
  assign sep = host_style_select != 3'h1;

  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence sep_rd_go;
    sep && !cs_n && write_strobe_n && $fell(read_data_strobe_n);
  endsequence

  sequence ds_go;
    !sep && !cs_n && $fell(read_data_strobe_n);
  endsequence

  rd_drive_a: assert property (sep_rd_go |-> ##[1:6] dev_data_oe)
    else $error("read strobe did not enable data drivers");
  rd_wait_a: assert property (sep_rd_go |-> ##[1:6] !transfer_ack_out)
    else $error("ready did not drop after read strobe");
  rd_ready_a: assert property ($fell(transfer_ack_out) && sep |-> ##[1:4] transfer_ack_out)
    else $error("ready did not return after settle time");
  rd_release_a: assert property (sep && $rose(read_data_strobe_n) |-> ##[1:6] !dev_data_oe)
    else $error("data bus not released after read");
  oe_cause_a: assert property ($rose(dev_data_oe) |-> !cs_n && !read_data_strobe_n)
    else $error("data drivers enabled without select and strobe");
  wr_input_a: assert property (sep && !write_strobe_n |-> !dev_data_oe && transfer_ack_out)
    else $error("port drove bus or dropped ready during write");
  ds_ack_a: assert property (ds_go |-> ##[1:8] !transfer_ack_out)
    else $error("no acknowledge in direction style");
  host_wait_a: assert property (sep && $rose(read_data_strobe_n) |-> $past(transfer_ack_out))
    else $error("host ended read before ready");
  addr_latch_a: assert property (sep && $fell(address_latch_strobe) |-> !cs_n && $stable(addr))
    else $error("address unstable or unselected at latch edge");
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench: host end and framer end joined by the pin interface.
// Assumes the command port of the host end is the only way software reaches registers.
`timescale 1ns/1ps
`include "hbp_defs.svh"
module tb_top;
  logic       ref_clk_in;
  logic       rst_n_in;
  logic       cmd_valid_in;
  logic       cmd_write_in;
  logic       cmd_ready_out;
  logic       rsp_valid_out;
  logic [2:0] host_style_in;
  logic [6:0] cmd_addr_in;
  logic [6:0] reg_wr_addr_out;
  logic [7:0] cmd_wdata_in;
  logic [7:0] rsp_rdata_out;
  logic [7:0] reg_wr_data_out;
  logic [7:0] rd;
  logic [3:0] viol_event_in;
  logic       reg_wr_pulse_out;
  int         pulses;
  logic [3:0] page_group_out;
  logic [1:0] page_set_out;
  logic [6:0] wa [3];
  logic [7:0] wd [3];
  int         miscompares;
  int         comparisons;

  hbp_if hbp_if_inst ();

  hbp_device hbp_device_inst (
    .ref_clk_in       (ref_clk_in),
    .rst_n_in         (rst_n_in),
    .bus              (hbp_if_inst),
    .viol_event_in    (viol_event_in),
    .reg_wr_pulse_out (reg_wr_pulse_out),
    .reg_wr_addr_out  (reg_wr_addr_out),
    .reg_wr_data_out  (reg_wr_data_out),
    .page_set_out     (page_set_out),
    .page_group_out   (page_group_out)
  );

  hbp_host hbp_host_inst (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .bus           (hbp_if_inst),
    .host_style_in (host_style_in),
    .cmd_valid_in  (cmd_valid_in),
    .cmd_write_in  (cmd_write_in),
    .cmd_addr_in   (cmd_addr_in),
    .cmd_wdata_in  (cmd_wdata_in),
    .cmd_ready_out (cmd_ready_out),
    .rsp_valid_out (rsp_valid_out),
    .rsp_rdata_out (rsp_rdata_out)
  );

  hbp_monitor hbp_monitor_inst (
    .ref_clk_in           (ref_clk_in),
    .rst_n_in             (rst_n_in),
    .host_style_select    (hbp_if_inst.host_style_select),
    .cs_n                 (hbp_if_inst.cs_n),
    .address_latch_strobe (hbp_if_inst.address_latch_strobe),
    .read_data_strobe_n   (hbp_if_inst.read_data_strobe_n),
    .write_strobe_n       (hbp_if_inst.write_strobe_n),
    .addr                 (hbp_if_inst.addr),
    .dev_data_oe          (hbp_if_inst.dev_data_oe),
    .transfer_ack_out     (hbp_if_inst.transfer_ack_out)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded at 400 cycles so that a dead handshake counts a mismatch here instead of waiting for the watchdog.
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge ref_clk_in);
    while (cmd_ready_out !== 1'b1 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
    end
  endtask

  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    wait_idle();
    cmd_valid_in <= 1'b1;
    cmd_write_in <= w;
    cmd_addr_in  <= a;
    cmd_wdata_in <= d;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    while (!w && rsp_valid_out !== 1'b1 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
    end
    rd = rsp_rdata_out;
    wait_idle();
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // Each landed write must give exactly one pulse.
  always @(posedge ref_clk_in) begin
    if (reg_wr_pulse_out === 1'b1) begin
      pulses++;
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    end_of_test();
  end

  initial begin
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_write_in = 1'b0;
    cmd_addr_in = 7'h00;
    cmd_wdata_in = 8'h00;
    host_style_in = 3'h0;
    viol_event_in = 4'h0;
    pulses = 0;
    miscompares = 0;
    comparisons = 0;
    wa = '{7'h05, 7'h06, 7'h3F};
    wd = '{8'hA5, 8'h5A, 8'hC3};
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rchk(`HBP_PAGE_OFF, 8'h00);
    acc(1'b1, `HBP_PAGE_OFF, 8'h16);
    chk({6'h00, page_set_out}, 8'h02);
    chk({4'h0, page_group_out}, 8'h05);
    rchk(`HBP_PAGE_OFF, 8'h16);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, wa[i], wd[i]);
      chk({1'b0, reg_wr_addr_out}, {1'b0, wa[i]});
      chk(reg_wr_data_out, wd[i]);
    end
    chk(8'(pulses), 8'h04);
    acc(1'b1, 7'h45, 8'h77);
    for (int i = 0; i < 3; i++) begin
      rchk(wa[i], wd[i]);
    end
    rchk(7'h45, 8'h00);
    // Set 2 sees 258 events, set 1 only the first 4, so the sets must stay apart.
    for (int i = 0; i < 258; i++) begin
      @(posedge ref_clk_in);
      viol_event_in <= (i < 4) ? 4'h6 : 4'h4;
    end
    @(posedge ref_clk_in);
    viol_event_in <= 4'h0;
    rchk(`HBP_VIOL_HI_OFF, 8'h01);
    rchk(`HBP_VIOL_LO_OFF, 8'h02);
    rchk(`HBP_VIOL_LO_OFF, 8'h00);
    rchk(`HBP_VIOL_HI_OFF, 8'h00);
    acc(1'b1, `HBP_PAGE_OFF, 8'h01);
    rchk(`HBP_VIOL_LO_OFF, 8'h04);
    for (int s = 1; s < 4; s += 2) begin
      host_style_in <= 3'(s);
      repeat (2) @(posedge ref_clk_in);
      acc(1'b1, 7'h10, 8'h30 + 8'(s));
      rchk(7'h10, 8'h30 + 8'(s));
    end
    host_style_in <= 3'h0;
    end_of_test();
  end
endmodule
